// [rtl/sfi_pkg.sv]
package sfi_pkg;

  // ----------------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] OPC_WREN  = 8'h06;
  localparam logic [7:0] OPC_WRDI  = 8'h04;
  localparam logic [7:0] OPC_RDSR  = 8'h05;
  localparam logic [7:0] OPC_WRSR  = 8'h01;
  localparam logic [7:0] OPC_READ  = 8'h03;
  localparam logic [7:0] OPC_FSTRD = 8'h0b;
  localparam logic [7:0] OPC_WRITE = 8'h02;
  localparam logic [7:0] OPC_SLEEP = 8'hb9;
  localparam logic [7:0] OPC_RDID  = 8'h9f;

  // ----------------------------------------------------------------------
  // array geometry, status layout and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W     = 18;
  localparam int unsigned MEM_DEPTH  = 262144;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned SR_GUARD   = 7;
  localparam int unsigned SR_BP_HI   = 3;
  localparam int unsigned SR_BP_LO   = 2;
  localparam logic [1:0]  ADDR_LAST  = 2'h2;
  localparam logic [1:0]  WRSR_DONE  = 2'h3;
  localparam logic [2:0]  BIT_LAST   = 3'h7;
  // fixed status bits: bit 6 reads one, bits 5:4 and 0 read zero
  localparam logic [7:0]  SR_FIXED   = 8'h40;
  // arbitrary neutral identity byte returned for the id command
  localparam logic [7:0]  ID_DEFAULT = 8'h5a;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_OPC   = 3'b001,
    ST_ADDR  = 3'b011,
    ST_DUMMY = 3'b010,
    ST_DATA  = 3'b110,
    ST_IGNR  = 3'b111
  } sfi_state_t;

  typedef struct packed {
    logic wp_n;
    logic si;
    logic sck;
    logic cs_n;
  } sfi_pins_t;

  localparam sfi_pins_t PINS_RST = '{wp_n: 1'b1, si: 1'b0, sck: 1'b0, cs_n: 1'b1};

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } sfi_wr_req_t;

endpackage : sfi_pkg

// [rtl/sfi_top.sv]
`timescale 1ns/100ps

// --------------------------------------------------------------------------
// write buffer between the serial front end and the array
// --------------------------------------------------------------------------
module sfi_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_sys_i,
  input  wire logic             arst_n_i,
  input  wire logic             ce_i,
  input  wire logic             in_valid_i,
  output      logic             in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output      logic             out_valid_o,
  input  wire logic             out_ready_i,
  output      logic [WIDTH-1:0] out_data_o
);
  // depth must be a power of two; the extra pointer bit tells full from empty
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] buf_q [DEPTH];
  logic [AW:0]      wr_ptr_ff;
  logic [AW:0]      rd_ptr_ff;
  wire              push_w;
  wire              pop_w;

  // flags and handshakes
  assign in_ready_o  = (wr_ptr_ff[AW-1:0] != rd_ptr_ff[AW-1:0]) | (wr_ptr_ff[AW] == rd_ptr_ff[AW]);
  assign out_valid_o = (wr_ptr_ff != rd_ptr_ff);
  assign out_data_o  = buf_q[rd_ptr_ff[AW-1:0]];
  assign push_w      = in_valid_i & in_ready_o;
  assign pop_w       = out_valid_o & out_ready_i;

  // pointers
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else if (ce_i) begin
      if (push_w) wr_ptr_ff <= wr_ptr_ff + (AW+1)'(1);
      if (pop_w)  rd_ptr_ff <= rd_ptr_ff + (AW+1)'(1);
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk_sys_i) begin
    if (ce_i && push_w) buf_q[wr_ptr_ff[AW-1:0]] <= in_data_i;
  end

endmodule : sfi_fifo

// Overview of operation
// RQ1: while deselected, stay in standby, ignore inputs, keep output undriven.
// RQ2: master starts each opcode with a new select and deselects afterwards.
// RQ3: first byte after select is the opcode, then address, then data.
// RQ4: inputs captured on rising serial clock, output changes on falling edge.
// RQ5: any serial clock rate up to maximum, including stops mid transfer.
// RQ6: output driven only while returning read data, otherwise high impedance.
// RQ7: status writes rejected when guard bit set and protect pin low.
// RQ8: eighteen bit byte address selects one of 262,144 bytes.
// RQ9: three address bytes taken, top six address bits ignored.
// RQ10: array writes finish at bus speed, no ready polling ever needed.
// RQ11: modes 0 and 3, sampling from first rising edge after select.
// RQ12: never starts activity alone, acts only on selected master commands.
// RQ13: master may tie input and output together relying on tristate.
// RQ14: every byte shifted most significant bit first both directions.
// RQ15: unknown opcode ignored with all input until next select, output undriven.
// RQ16: clock low at select means mode 0, clock high means mode 3.
// RQ17: deselect mid byte drops partial byte and clears bit and byte counts.
module sfi_top #(
  parameter logic [7:0] ID_BYTE = sfi_pkg::ID_DEFAULT
) (
  input  wire logic clk_sys_i,
  input  wire logic arst_n_i,
  input  wire logic ce_i,
  input  wire logic cs_n_i,
  input  wire logic sck_i,
  input  wire logic si_i,
  input  wire logic wp_n_i,
  output      logic so_o,
  output      logic so_oe_o
);
  import sfi_pkg::*;

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  sfi_pins_t         meta_ff;
  sfi_pins_t         sync_ff;
  sfi_pins_t         prev_ff;
  sfi_state_t        st_ff;
  sfi_state_t        nxt_st;
  sfi_state_t        opc_next_w;
  sfi_wr_req_t       push_req_ff;
  sfi_wr_req_t       pop_req_w;
  logic [7:0]        cmd_ff;
  logic [7:0]        rx_sh_ff;
  logic [2:0]        bit_cnt_ff;
  logic [1:0]        byte_cnt_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [6:0]        tx_sh_ff;
  logic [2:0]        tx_cnt_ff;
  logic [7:0]        rd_byte_ff;
  logic [7:0]        mem_q [MEM_DEPTH];
  logic [1:0]        bp_ff;
  logic              guard_pin_honour_bit_ff;
  logic              wel_ff;
  logic              wel_clr_ff;
  logic              push_vld_ff;
  logic              mode3_ff;
  logic              rise_seen_ff;
  logic              so_ff;
  logic              oe_ff;
  wire               sel_w;
  wire               cs_fall_w;
  wire               cs_rise_w;
  wire               sck_rise_w;
  wire               sck_fall_w;
  wire               byte_done_w;
  wire  [7:0]        rx_byte_w;
  wire  [7:0]        sr_w;
  wire  [7:0]        tx_src_w;
  wire               rd_cmd_w;
  wire               rd_phase_w;
  wire               tx_load_w;
  wire               wr_ok_w;
  wire               sr_wr_w;
  wire               sr_locked_w;
  wire               fifo_in_rdy_w;
  wire               pop_vld_w;
  wire               drain_rdy_w;

  // --------------------------------------------------------------------------
  // pin synchronisers and edge detection
  // --------------------------------------------------------------------------
  // two stages before any use; only the second stage and its delayed copy feed logic
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_ff <= PINS_RST;
      sync_ff <= PINS_RST;
      prev_ff <= PINS_RST;
    end else if (ce_i) begin
      meta_ff <= '{wp_n: wp_n_i, si: si_i, sck: sck_i, cs_n: cs_n_i};
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // RQ5 edges not rates
  // clock edges are found by sampling, so a stopped clock simply produces none
  assign sel_w      = !sync_ff.cs_n;
  assign cs_fall_w  = prev_ff.cs_n & !sync_ff.cs_n;
  assign cs_rise_w  = !prev_ff.cs_n & sync_ff.cs_n;
  assign sck_rise_w = sel_w & !cs_fall_w & !prev_ff.sck & sync_ff.sck;
  // RQ11 first rise counts
  // in mode 3 the idle-high clock may fall before the first rise: not a data edge
  assign sck_fall_w = sel_w & prev_ff.sck & !sync_ff.sck & (rise_seen_ff | !mode3_ff);

  // --------------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------------
  // RQ14 msb first in
  assign rx_byte_w   = {rx_sh_ff[6:0], sync_ff.si};
  assign byte_done_w = sck_rise_w & (bit_cnt_ff == BIT_LAST);
  assign sr_w        = SR_FIXED | {guard_pin_honour_bit_ff, 3'h0, bp_ff, wel_ff, 1'b0};
  assign rd_cmd_w    = (cmd_ff == OPC_RDSR) | (cmd_ff == OPC_READ) |
                       (cmd_ff == OPC_FSTRD) | (cmd_ff == OPC_RDID);
  assign rd_phase_w  = (st_ff == ST_DATA) & rd_cmd_w;
  assign tx_load_w   = rd_phase_w & sck_fall_w & (tx_cnt_ff == 3'h0);
  assign tx_src_w    = (cmd_ff == OPC_RDSR) ? sr_w :
                       (cmd_ff == OPC_RDID) ? ID_BYTE : rd_byte_ff;
  // RQ7 guard pin lock
  assign sr_locked_w = guard_pin_honour_bit_ff & !sync_ff.wp_n;
  assign sr_wr_w     = byte_done_w & (st_ff == ST_DATA) & (cmd_ff == OPC_WRSR) &
                       (byte_cnt_ff != WRSR_DONE) & wel_ff & !sr_locked_w;
  // a held byte not yet taken by the buffer causes the next byte to be dropped
  assign wr_ok_w     = byte_done_w & (st_ff == ST_DATA) & (cmd_ff == OPC_WRITE) &
                       wel_ff & !(push_vld_ff & !fifo_in_rdy_w);

  // RQ15 unknown opcode ignored
  // sleep is accepted but not modelled, so it idles like an ignored command
  assign opc_next_w  = ((rx_byte_w == OPC_READ) | (rx_byte_w == OPC_FSTRD) |
                        (rx_byte_w == OPC_WRITE)) ? ST_ADDR :
                       ((rx_byte_w == OPC_RDSR) | (rx_byte_w == OPC_WRSR) |
                        (rx_byte_w == OPC_RDID)) ? ST_DATA : ST_IGNR;

  // --------------------------------------------------------------------------
  // command sequencer
  // --------------------------------------------------------------------------
  // RQ1 idle when deselected
  // RQ3 opcode then address
  always_comb begin
    nxt_st = st_ff;
    if (cs_fall_w) begin
      nxt_st = ST_OPC;
    end else if (!sel_w) begin
      nxt_st = ST_IDLE;
    end else if (byte_done_w) begin
      unique case (st_ff)
        ST_OPC:   nxt_st = opc_next_w;
        ST_ADDR:  if (byte_cnt_ff == ADDR_LAST) begin
                    nxt_st = (cmd_ff == OPC_FSTRD) ? ST_DUMMY : ST_DATA;
                  end
        ST_DUMMY: nxt_st = ST_DATA;
        default:  nxt_st = st_ff;
      endcase
    end
  end

  // RQ12 selected only
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_ff    <= ST_IDLE;
      cmd_ff   <= 8'h00;
      mode3_ff <= 1'b0;
    end else if (ce_i) begin
      st_ff <= nxt_st;
      if (byte_done_w && st_ff == ST_OPC) cmd_ff <= rx_byte_w;
      // RQ16 mode from clock
      if (cs_fall_w) mode3_ff <= sync_ff.sck;
    end
  end

  // --------------------------------------------------------------------------
  // receive shifter and counters
  // --------------------------------------------------------------------------
  // RQ17 drop partial byte
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bit_cnt_ff   <= 3'h0;
      rx_sh_ff     <= 8'h00;
      rise_seen_ff <= 1'b0;
    end else if (ce_i) begin
      if (cs_fall_w || !sel_w) begin
        bit_cnt_ff   <= 3'h0;
        rise_seen_ff <= 1'b0;
      end else if (sck_rise_w) begin
        // RQ4 capture on rise
        bit_cnt_ff   <= bit_cnt_ff + 3'h1;
        rx_sh_ff     <= rx_byte_w;
        rise_seen_ff <= 1'b1;
      end
    end
  end

  // RQ9 three address bytes
  // shifting into 18 bits discards the first six address bits on the way
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      byte_cnt_ff <= 2'h0;
      addr_ff     <= '0;
    end else if (ce_i) begin
      if (cs_fall_w || !sel_w) begin
        byte_cnt_ff <= 2'h0;
      end else if (byte_done_w && st_ff == ST_ADDR) begin
        byte_cnt_ff <= byte_cnt_ff + 2'h1;
        addr_ff     <= {addr_ff[ADDR_W-9:0], rx_byte_w};
      end else if (sr_wr_w) begin
        byte_cnt_ff <= WRSR_DONE;
      end else if (wr_ok_w || (tx_load_w && cmd_ff != OPC_RDSR && cmd_ff != OPC_RDID)) begin
        // RQ8 wraps within array
        addr_ff <= addr_ff + ADDR_W'(1);
      end
    end
  end

  // --------------------------------------------------------------------------
  // status bits and write latch
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      guard_pin_honour_bit_ff <= SR_FIXED[SR_GUARD];
      bp_ff                   <= SR_FIXED[SR_BP_HI:SR_BP_LO];
      wel_ff                  <= 1'b0;
      wel_clr_ff              <= 1'b0;
    end else if (ce_i) begin
      // RQ7 locked status write
      if (sr_wr_w) begin
        guard_pin_honour_bit_ff <= rx_byte_w[SR_GUARD];
        bp_ff                   <= rx_byte_w[SR_BP_HI:SR_BP_LO];
      end
      if (byte_done_w && st_ff == ST_OPC) begin
        if (rx_byte_w == OPC_WREN) wel_ff <= 1'b1;
        wel_clr_ff <= (rx_byte_w == OPC_WRDI) | (rx_byte_w == OPC_WRSR) |
                      (rx_byte_w == OPC_WRITE);
      end else if (cs_rise_w) begin
        // latch drops only once the select ends, never mid command
        if (wel_clr_ff) wel_ff <= 1'b0;
        wel_clr_ff <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // write path: buffer then array
  // --------------------------------------------------------------------------
  // RQ10 bus speed writes
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      push_vld_ff <= 1'b0;
      push_req_ff <= '0;
    end else if (ce_i) begin
      if (wr_ok_w) begin
        push_vld_ff <= 1'b1;
        push_req_ff <= '{addr: addr_ff, data: rx_byte_w};
      end else if (fifo_in_rdy_w) begin
        push_vld_ff <= 1'b0;
      end
    end
  end

  sfi_fifo #(
    .WIDTH ($bits(sfi_wr_req_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_sys_i   (clk_sys_i),
    .arst_n_i    (arst_n_i),
    .ce_i        (ce_i),
    .in_valid_i  (push_vld_ff),
    .in_ready_o  (fifo_in_rdy_w),
    .in_data_i   (push_req_ff),
    .out_valid_o (pop_vld_w),
    .out_ready_i (drain_rdy_w),
    .out_data_o  (pop_req_w)
  );

  // single-port array: a read phase owns the port, writes wait in the buffer
  assign drain_rdy_w = !rd_phase_w;

  always_ff @(posedge clk_sys_i) begin
    if (ce_i) begin
      if (pop_vld_w && drain_rdy_w) begin
        mem_q[pop_req_w.addr] <= pop_req_w.data;
      end else begin
        rd_byte_ff <= mem_q[addr_ff];
      end
    end
  end

  // --------------------------------------------------------------------------
  // transmit shifter and output enable
  // --------------------------------------------------------------------------
  // RQ6 drive only reads
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      so_ff     <= 1'b0;
      oe_ff     <= 1'b0;
      tx_sh_ff  <= 7'h00;
      tx_cnt_ff <= 3'h0;
    end else if (ce_i) begin
      if (!rd_phase_w || !sel_w) begin
        // RQ13 shared data line
        oe_ff     <= 1'b0;
        tx_cnt_ff <= 3'h0;
      end else if (tx_load_w) begin
        // RQ14 msb first out
        so_ff     <= tx_src_w[7];
        tx_sh_ff  <= tx_src_w[6:0];
        tx_cnt_ff <= BIT_LAST;
        oe_ff     <= 1'b1;
      end else if (sck_fall_w) begin
        // RQ4 change on fall
        so_ff     <= tx_sh_ff[6];
        tx_sh_ff  <= {tx_sh_ff[5:0], 1'b0};
        tx_cnt_ff <= tx_cnt_ff - 3'h1;
      end
    end
  end

  assign so_o    = so_ff;
  assign so_oe_o = oe_ff;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i iff ce_i); endclocking
  default disable iff (!arst_n_i);

  a_standby_tristate: assert property (!sel_w |=> !so_oe_o && st_ff == ST_IDLE) // RQ1
    else $error("output driven or busy while deselected");
  a_oe_read_only: assert property (so_oe_o |-> $past(rd_phase_w)) // RQ6
    else $error("output enabled outside read data");
  a_first_opcode: assert property (cs_fall_w |=> st_ff == ST_OPC && bit_cnt_ff == 3'h0) // RQ3
    else $error("select did not start opcode byte");
  a_rx_on_rise: assert property (sel_w && $past(sel_w) && bit_cnt_ff != $past(bit_cnt_ff)
                                 |-> $past(sck_rise_w)) // RQ4
    else $error("bit count moved without rising clock");
  a_tx_on_fall: assert property (so_oe_o && $past(so_oe_o) && $changed(so_o)
                                 |-> $past(sck_fall_w)) // RQ4
    else $error("output changed without falling clock");
  a_wp_blocks_sr: assert property (sr_locked_w && byte_done_w && cmd_ff == OPC_WRSR
                                   |=> $stable(guard_pin_honour_bit_ff) && $stable(bp_ff)) // RQ7
    else $error("status written while protect pin held");
  a_addr_low_bits: assert property (byte_done_w && st_ff == ST_ADDR && byte_cnt_ff == ADDR_LAST
                                    |=> addr_ff[7:0] == $past(rx_byte_w)) // RQ9
    else $error("last address byte not placed low");
  a_ignore_holds: assert property (st_ff == ST_IGNR && sel_w && !cs_fall_w
                                   |=> st_ff == ST_IGNR && !so_oe_o) // RQ15
    else $error("ignored command left its state");
  a_mode_latch: assert property (cs_fall_w |=> mode3_ff == $past(sync_ff.sck)) // RQ16
    else $error("mode not taken from clock level");
  a_partial_drop: assert property (cs_rise_w |=> bit_cnt_ff == 3'h0 && byte_cnt_ff == 2'h0) // RQ17
    else $error("counters kept after deselect");
  a_write_drains: assert property (push_vld_ff && fifo_in_rdy_w && !rd_phase_w
                                   |-> ##[1:12] !pop_vld_w) // RQ10
    else $error("write buffer did not drain");

  c_mode3_select: cover property (cs_fall_w && sync_ff.sck);
  c_read_driven:  cover property (tx_load_w && cmd_ff == OPC_READ);
  c_write_pushed: cover property (wr_ok_w);
  c_ignored_opc:  cover property (st_ff == ST_OPC && byte_done_w && opc_next_w == ST_IGNR);

endmodule : sfi_top

// [dv/sfi_spi_master.sv]
`timescale 1ns/100ps

// --------------------------------------------------------------------------
// bus master model driving the serial pins
// --------------------------------------------------------------------------
module sfi_spi_master (
  input  wire logic clk_sys_i,
  input  wire logic so_i,
  input  wire logic so_oe_i,
  output      logic cs_n_o,
  output      logic sck_o,
  output      logic si_o
);
  logic oe_seen   = 1'b0;
  logic miso_last = 1'b0;
  logic cs_q      = 1'b1;
  logic cs_prev   = 1'b1;
  logic sck_q     = 1'b0;
  logic si_q      = 1'b0;
  logic si_idle   = 1'b0;
  bit   mode3;

  // released data line toggles so no stale level can pass for a bit
  assign cs_n_o = cs_q;
  assign sck_o  = sck_q;
  assign si_o   = cs_q ? si_idle : si_q;

  // read enable seen in the current select, cleared when the select starts
  always @(negedge clk_sys_i) begin
    si_idle <= ~si_idle;
    cs_prev <= cs_q;
    if (cs_prev && !cs_q) oe_seen <= 1'b0;
    else if (so_oe_i) oe_seen <= 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : hold

  task automatic sel(input bit m3);
    mode3 = m3;
    hold(1);
    sck_q <= m3;
    hold(4);
    cs_q <= 1'b0;
    hold(8);
  endtask : sel

  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      sck_q <= 1'b0;
      si_q  <= tx[i];
      hold(8);
      // released line model
      // undriven line reads as inverse of last bit, never a steady stale level
      rx[i] = so_oe_i ? so_i : ~miso_last;
      miso_last = rx[i];
      sck_q <= 1'b1;
      // clock paused mid-byte on some bytes, slow and fast halves mixed
      hold(8 + ((i == 4) ? 40 * tx[0] : 0));
    end
  endtask : xfer

  task automatic desel();
    sck_q <= mode3;
    hold(8);
    cs_q <= 1'b1;
    hold(8);
  endtask : desel
endmodule : sfi_spi_master

// [dv/sfi_tb_top.sv]
`timescale 1ns/100ps

`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value at %0t ns: got %h expected %h", $time, g, e); end end

// --------------------------------------------------------------------------
// self-checking bench with a byte-level reference model
// --------------------------------------------------------------------------
module sfi_tb_top;
  import sfi_pkg::*;
  // arbitrary identity byte for the bench
  localparam logic [7:0] ID_TB = 8'ha7;

  logic       clk;
  logic       ce = 1'b1;
  int         ce_cnt = 0;
  logic       rst_n;
  logic       wp_n;
  logic       cs_n;
  logic       sck;
  logic       si;
  logic       so;
  logic       so_oe;
  int         fail_count;
  int         cmp_count;
  int         seed;
  logic [7:0] st;
  logic [7:0] mem [int];

  sfi_top #(.ID_BYTE(ID_TB)) dut (
    .clk_sys_i(clk), .arst_n_i(rst_n), .ce_i(ce), .cs_n_i(cs_n), .sck_i(sck),
    .si_i(si), .wp_n_i(wp_n), .so_o(so), .so_oe_o(so_oe)
  );

  sfi_spi_master u_m (
    .clk_sys_i(clk), .so_i(so), .so_oe_i(so_oe), .cs_n_o(cs_n), .sck_o(sck), .si_o(si)
  );

  always #5 clk = ~clk;

  // enable drops one cycle in seven; sck halves keep six live cycles
  always @(negedge clk) begin
    ce_cnt <= (ce_cnt + 1) % 7;
    ce     <= (ce_cnt != 6);
  end

  task automatic report_and_stop();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  // one whole command: opcode, address, n data bytes, then deselect
  task automatic run(input bit m3, input logic [7:0] op, input logic [23:0] a,
                     input int n, input logic [7:0] d);
    logic [7:0] rx;
    logic [7:0] tx;
    logic [7:0] ex;
    bit         rd;
    int         ad;
    rd = (op == OPC_READ || op == OPC_FSTRD || op == OPC_RDSR || op == OPC_RDID);
    ad = int'(a[17:0]);
    u_m.sel(m3);
    u_m.xfer(op, 8, rx);
    if (op == OPC_READ || op == OPC_WRITE || op == OPC_FSTRD) begin
      for (int i = 0; i < 3; i++) u_m.xfer(a[23-8*i -: 8], 8, rx);
    end
    if (op == OPC_FSTRD) u_m.xfer(8'h00, 8, rx);
    for (int i = 0; i < n; i++) begin
      tx = (op == OPC_WRSR) ? d : 8'($random(seed));
      u_m.xfer(tx, 8, rx);
      ex = (op == OPC_RDSR) ? st : (op == OPC_RDID) ? ID_TB :
           mem.exists(ad) ? mem[ad] : 8'h00;
      if (op == OPC_WRSR && i == 0 && st[1] && !(st[SR_GUARD] && !wp_n))
        st = {tx[7], 3'b100, tx[3:2], st[1], 1'b0};
      if (op == OPC_WRITE && st[1]) mem[ad] = tx;
      if (rd) `CHK(rx, ex)
      ad = (ad + 1) % MEM_DEPTH;
    end
    u_m.desel();
    if (op == OPC_WREN) st[1] = 1'b1;
    if (op == OPC_WRDI || op == OPC_WRSR || op == OPC_WRITE) st[1] = 1'b0;
    `CHK(u_m.oe_seen, rd && n > 0)
    `CHK(so_oe, 1'b0)
  endtask : run

  // watchdog sized well above the expected run length
  initial begin
    #400000;
    fail_count++;
    report_and_stop();
  end

  initial begin
    logic [7:0] rx;
    clk = 1'b0; rst_n = 1'b0; wp_n = 1'b1; seed = 88; st = SR_FIXED;
    fail_count = 0; cmp_count = 0;
    repeat (4) @(negedge clk);
    rst_n <= 1'b1;
    repeat (4) @(negedge clk);
    `CHK(so_oe, 1'b0)
    run(0, OPC_RDSR, '0, 2, 8'h00);
    run(1, OPC_RDID, '0, 2, 8'h00);
    run(0, OPC_WREN, '0, 0, 8'h00);
    run(1, OPC_RDSR, '0, 1, 8'h00);
    run(0, OPC_WRITE, 24'hfffffe, 12, 8'h00);
    run(1, OPC_READ, 24'h03fffe, 12, 8'h00);
    run(0, OPC_FSTRD, 24'hc00004, 5, 8'h00);
    run(1, OPC_WRITE, 24'h000003, 2, 8'h00);
    run(0, OPC_READ, 24'h000002, 3, 8'h00);
    run(0, 8'hff, '0, 3, 8'h00);
    run(1, OPC_SLEEP, '0, 2, 8'h00);
    run(0, OPC_WREN, '0, 0, 8'h00);
    run(1, OPC_WRDI, '0, 0, 8'h00);
    run(0, OPC_RDSR, '0, 1, 8'h00);
    u_m.sel(1'b0);
    u_m.xfer(OPC_WREN, 5, rx);
    u_m.desel();
    run(0, OPC_RDSR, '0, 1, 8'h00);
    // set guard, refuse with pin low, clear with pin high
    for (int k = 0; k < 3; k++) begin
      wp_n <= (k != 1);
      run(k[0], OPC_WREN, '0, 0, 8'h00);
      run(0, OPC_WRSR, '0, 1, (k == 0) ? 8'h8c : 8'h00);
      run(1, OPC_RDSR, '0, 1, 8'h00);
    end
    // second reset mid run must drop the write latch again
    run(0, OPC_WREN, '0, 0, 8'h00);
    rst_n <= 1'b0;
    repeat (2) @(negedge clk);
    rst_n <= 1'b1;
    st = SR_FIXED;
    repeat (4) @(negedge clk);
    `CHK(so_oe, 1'b0)
    run(1, OPC_RDSR, '0, 1, 8'h00);
    report_and_stop();
  end
endmodule : sfi_tb_top
